// ==== pkg/ntu_pkg.sv ====
// constants, types and register map of the notch configuration and resonance supervisor
package ntu_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned     NTU_CLK_HZ          = 10_000_000;
	localparam int unsigned     NTU_SETTLE_FAST_MS  = 150;
	localparam int unsigned     NTU_SETTLE_SLOW_MS  = 500;
	localparam int unsigned     NTU_WARN_S          = 5;
	localparam int unsigned     NTU_NVM_PERIOD_MIN  = 5;
	localparam longint unsigned NTU_SETTLE_FAST_CYC = (longint'(NTU_SETTLE_FAST_MS) * NTU_CLK_HZ) / 1000;
	localparam longint unsigned NTU_SETTLE_SLOW_CYC = (longint'(NTU_SETTLE_SLOW_MS) * NTU_CLK_HZ) / 1000;
	localparam longint unsigned NTU_WARN_CYC        = longint'(NTU_WARN_S) * NTU_CLK_HZ;
	localparam longint unsigned NTU_NVM_PERIOD_CYC  = longint'(NTU_NVM_PERIOD_MIN) * 60 * NTU_CLK_HZ;

	// ************************************************************
	// register map, byte offsets
	// ************************************************************
	localparam logic [7:0] NTU_REG_NOTCH  = 8'h00;
	localparam logic [7:0] NTU_REG_MODE   = 8'h04;
	localparam logic [7:0] NTU_REG_FILT1  = 8'h08;
	localparam logic [7:0] NTU_REG_FILT2  = 8'h0C;
	localparam logic [7:0] NTU_REG_THRESH = 8'h10;
	localparam logic [7:0] NTU_REG_FILT3  = 8'h14;
	localparam logic [7:0] NTU_REG_FILT4  = 8'h18;
	localparam logic [7:0] NTU_REG_FILT5  = 8'h1C;
	localparam logic [7:0] NTU_REG_STAT   = 8'h20;
	localparam logic [7:0] NTU_REG_MASK   = 8'h24;
	localparam logic [7:0] NTU_REG_COUNT  = 8'h28;
	localparam logic [7:0] NTU_REG_LIVE   = 8'h2C;

	// field positions
	localparam int unsigned NTU_NOTCH_DEPTH_POS = 8;
	localparam int unsigned NTU_MODE_TUNE_POS   = 2;
	localparam int unsigned NTU_MODE_F2SEL_POS  = 4;
	localparam int unsigned NTU_STAT_UPD        = 0;
	localparam int unsigned NTU_STAT_NVM        = 1;
	localparam int unsigned NTU_STAT_APPLY      = 2;

	// reset values
	localparam logic [15:0] NTU_FILT_RST   = 16'h1194;
	localparam logic [15:0] NTU_THRESH_RST = 16'h0032;

	// ************************************************************
	// values and types
	// ************************************************************
	localparam logic [15:0] NTU_MIN_DET_HZ    = 16'h0064;
	localparam logic [17:0] NTU_FAST_MIN_CHZ  = 18'h001C2;
	localparam logic [1:0]  NTU_TUNE_OFF      = 2'h0;
	localparam logic [1:0]  NTU_TUNE_MANUAL   = 2'h2;

	typedef enum logic [1:0] {NTU_MODE_OFF, NTU_MODE_CHANGE, NTU_MODE_AUTO} ntu_mode_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] level;
		logic [15:0] freq;
	} ntu_det_t;

	typedef struct packed {
		logic        enable;
		logic [17:0] freq_chz;
		logic [8:0]  depth_ddb;
	} ntu_notch_t;

endpackage : ntu_pkg

// ==== hdl/ntu_notch_decode.sv ====
// lookup of command notch centre frequency and depth
`timescale 1ns/1ps
`default_nettype none

module ntu_notch_decode
	import ntu_pkg::*;
(
	input  wire logic [6:0] i_code,
	input  wire logic [3:0] i_depth,
	output ntu_notch_t      o_notch
);

	// ************************************************************
	// tables
	// ************************************************************
	// centre frequency in 0.01 Hz; unlisted codes read 0 and act as off
	localparam logic [17:0] FREQ_TBL [0:127] = '{
		18'd0,    18'd200000, 18'd100000, 18'd66600, 18'd50000, 18'd0,     18'd40000, 18'd33300,
		18'd28500, 18'd25000, 18'd22200,  18'd20000, 18'd18100, 18'd16600, 18'd0,     18'd15300,
		18'd14200, 18'd13300, 18'd12500,  18'd11700, 18'd11100, 18'd10500, 18'd10000, 18'd9500,
		18'd0,    18'd9000,   18'd8600,   18'd8300,  18'd8000,  18'd7600,  18'd7400,  18'd7100,
		18'd0,    18'd6600,   18'd6200,   18'd5800,  18'd5500,  18'd5200,  18'd5000,  18'd4700,
		18'd0,    18'd4500,   18'd4300,   18'd4100,  18'd4000,  18'd3800,  18'd3700,  18'd3500,
		18'd3450, 18'd3330,   18'd3130,   18'd2940,  18'd2780,  18'd2630,  18'd2500,  18'd0,
		18'd2380, 18'd2270,   18'd2170,   18'd2080,  18'd2000,  18'd1920,  18'd1850,  18'd1790,
		18'd1720, 18'd1670,   18'd1560,   18'd1470,  18'd1390,  18'd1320,  18'd1250,  18'd0,
		18'd1190, 18'd1140,   18'd1090,   18'd1040,  18'd1000,  18'd960,   18'd930,   18'd890,
		18'd860,  18'd830,    18'd780,    18'd740,   18'd690,   18'd660,   18'd630,   18'd0,
		18'd600,  18'd570,    18'd540,    18'd520,   18'd500,   18'd480,   18'd460,   18'd450,
		18'd431,  18'd417,    18'd391,    18'd368,   18'd347,   18'd329,   18'd313,   18'd0,
		18'd298,  18'd284,    18'd272,    18'd260,   18'd250,   18'd240,   18'd231,   18'd223,
		18'd0,    18'd208,    18'd195,    18'd184,   18'd174,   18'd164,   18'd156,   18'd0,
		18'd149,  18'd142,    18'd136,    18'd130,   18'd125,   18'd120,   18'd116,   18'd112
	};
	// depth magnitude in 0.1 dB, deepest first
	localparam logic [8:0] DEPTH_TBL [0:15] = '{
		9'd400, 9'd241, 9'd181, 9'd145, 9'd120, 9'd101, 9'd85, 9'd72,
		9'd60,  9'd50,  9'd41,  9'd33,  9'd25,  9'd18,  9'd12, 9'd6
	};

	// plain lookup; the caller registers the result
	always_comb begin
		o_notch.freq_chz  = FREQ_TBL[i_code];
		o_notch.enable    = (FREQ_TBL[i_code] != 18'h00000);
		o_notch.depth_ddb = DEPTH_TBL[i_depth];
	end

endmodule // ntu_notch_decode

`default_nettype wire

// ==== hdl/ntu_supervisor.sv ====
// notch configuration and vibration supervisor with register port
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ntu_supervisor
	import ntu_pkg::*;
#(
	parameter int unsigned P_SETTLE_FAST_CYC = 32'(NTU_SETTLE_FAST_CYC),
	parameter int unsigned P_SETTLE_SLOW_CYC = 32'(NTU_SETTLE_SLOW_CYC),
	parameter int unsigned P_WARN_CYC        = 32'(NTU_WARN_CYC),
	parameter int unsigned P_NVM_CYC         = 32'(NTU_NVM_PERIOD_CYC)
)(
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	input  wire ntu_det_t    I_DET,
	input  wire logic        I_SERVO_LOCK,
	output logic [31:0]      O_RDATA,
	output logic             O_IRQ,
	output ntu_notch_t       O_NOTCH,
	output logic [15:0]      O_FILT_ONE,
	output logic [15:0]      O_FILT_TWO,
	output logic             O_TOUGH_WARN,
	output logic             O_NVM_SAVE
);

	// ************************************************************
	// helpers
	// ************************************************************
	// true when f lies within +-30 percent of the set value
	function automatic logic ntu_in_band(input logic [15:0] f, input logic [15:0] s);
		logic [19:0] a;
		a = 20'(f) * 20'd10;
		return (a >= 20'(s) * 20'd7) && (a <= 20'(s) * 20'd13);
	endfunction

	function automatic logic [15:0] ntu_dist(input logic [15:0] a, input logic [15:0] b);
		return (a >= b) ? (a - b) : (b - a);
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [10:0] notch_set, next_notch_set;
	logic [10:0] notch_live, next_notch_live;
	ntu_mode_t   mode, next_mode;
	logic [1:0]  tune, next_tune;
	logic        f2_sel, next_f2_sel;
	logic [15:0] filt1, next_filt1;
	logic [15:0] filt2, next_filt2;
	logic [15:0] thresh, next_thresh;
	logic [15:0] filt3, next_filt3;
	logic [15:0] filt4, next_filt4;
	logic [15:0] filt5, next_filt5;
	logic [2:0]  stat, next_stat;
	logic [2:0]  mask, next_mask;
	logic [15:0] count, next_count;
	logic [31:0] settle, next_settle;
	logic [31:0] warn_cnt, next_warn_cnt;
	logic [31:0] nvm_timer, next_nvm_timer;
	logic        nvm_dirty, next_nvm_dirty;
	logic [31:0] next_rdata;
	logic        next_irq;
	logic        next_warn;

	ntu_notch_t  live_dec;
	logic        det_ok, f1_man, f1_en, f2_en, win1, win2, pick1;
	logic        upd, upd1, upd2, apply, save_now, pending;
	logic [31:0] settle_need;

	// decoded view of the notch setting now in force
	ntu_notch_decode u_dec (
		.i_code  (notch_live[6:0]),
		.i_depth (notch_live[10:7]),
		.o_notch (live_dec)
	);

	// ************************************************************
	// resonance supervisor qualification
	// ************************************************************
	// everything is judged in the detector's own sample cycle
	always_comb begin
		f1_en  = (tune != NTU_TUNE_OFF);
		f1_man = (tune == NTU_TUNE_MANUAL);
		f2_en  = f2_sel;
		win1   = f1_man && ntu_in_band(I_DET.freq, filt1);
		win2   = f2_en && ntu_in_band(I_DET.freq, filt2);
		pick1  = ntu_dist(I_DET.freq, filt1) <= ntu_dist(I_DET.freq, filt2);
		det_ok = I_DET.valid && (mode != NTU_MODE_OFF)
			&& (I_DET.level > thresh)
			&& (I_DET.freq > NTU_MIN_DET_HZ);
		upd1 = 1'b0;
		upd2 = 1'b0;
		if (det_ok) begin
			if (f1_en && f2_en) begin
				// nearest wins, a tie goes to filter one
				upd1 = (win1 || win2) && pick1;
				upd2 = (win1 || win2) && !pick1;
			end else if (mode == NTU_MODE_AUTO && !f1_en && !f2_en) begin
				upd1 = 1'b1;
			end else if (mode == NTU_MODE_AUTO && !f2_en) begin
				upd2 = 1'b1;
			end else if (mode == NTU_MODE_AUTO && !f1_en) begin
				upd1 = 1'b1;
			end else begin
				upd1 = win1;
				upd2 = win2;
			end
		end
		upd = upd1 || upd2;
	end

	// ************************************************************
	// notch settle timer and storage throttle
	// ************************************************************
	always_comb begin
		pending     = (notch_set != notch_live);
		// a disabled notch has no settling to wait for, so the short wait applies
		settle_need = (!live_dec.enable || live_dec.freq_chz >= NTU_FAST_MIN_CHZ)
			? P_SETTLE_FAST_CYC : P_SETTLE_SLOW_CYC;
		apply       = pending && I_SERVO_LOCK && (settle >= settle_need - 32'h00000001);
		save_now    = nvm_dirty && (nvm_timer >= P_NVM_CYC);
	end

	// ************************************************************
	// next state for all registers
	// ************************************************************
	always_comb begin
		next_notch_set = notch_set;
		next_mode      = mode;
		next_tune      = tune;
		next_f2_sel    = f2_sel;
		next_filt1     = filt1;
		next_filt2     = filt2;
		next_thresh    = thresh;
		next_filt3     = filt3;
		next_filt4     = filt4;
		next_filt5     = filt5;
		next_mask      = mask;
		// software writes
		if (I_WR) begin
			unique case (I_ADDR)
				NTU_REG_NOTCH: begin
					next_notch_set = {I_WDATA[NTU_NOTCH_DEPTH_POS +: 4], I_WDATA[6:0]};
				end
				NTU_REG_MODE: begin
					unique case (I_WDATA[1:0])
						2'h1:    next_mode = NTU_MODE_CHANGE;
						2'h2:    next_mode = NTU_MODE_AUTO;
						default: next_mode = NTU_MODE_OFF;
					endcase
					next_tune   = I_WDATA[NTU_MODE_TUNE_POS +: 2];
					next_f2_sel = I_WDATA[NTU_MODE_F2SEL_POS];
				end
				NTU_REG_FILT1:  next_filt1  = I_WDATA[15:0];
				NTU_REG_FILT2:  next_filt2  = I_WDATA[15:0];
				NTU_REG_THRESH: next_thresh = I_WDATA[15:0];
				NTU_REG_FILT3:  next_filt3  = I_WDATA[15:0];
				NTU_REG_FILT4:  next_filt4  = I_WDATA[15:0];
				NTU_REG_FILT5:  next_filt5  = I_WDATA[15:0];
				NTU_REG_MASK:   next_mask   = I_WDATA[2:0];
				default: ;
			endcase
		end
		// hardware rewrite wins over a software write in the same cycle
		if (upd1) next_filt1 = I_DET.freq;
		if (upd2) next_filt2 = I_DET.freq;

		// notch setting takes effect only after lock has held long enough
		next_notch_live = apply ? notch_set : notch_live;
		next_settle     = (!pending || !I_SERVO_LOCK || apply) ? 32'h00000000 : settle + 32'h00000001;

		// warning window and event count
		next_count    = upd ? count + 16'h0001 : count;
		next_warn_cnt = upd ? P_WARN_CYC
			: (warn_cnt != 32'h00000000) ? warn_cnt - 32'h00000001 : warn_cnt;
		next_warn     = (next_warn_cnt != 32'h00000000);

		// storage copy: dirty set wins over the clear
		next_nvm_dirty = upd || (nvm_dirty && !save_now);
		next_nvm_timer = save_now ? 32'h00000001
			: (nvm_timer < P_NVM_CYC) ? nvm_timer + 32'h00000001 : nvm_timer;

		// sticky status: a read clears, a new event in that cycle survives
		next_stat = ((I_RD && I_ADDR == NTU_REG_STAT) ? 3'h0 : stat)
			| {apply, save_now, upd};
		next_irq  = |(next_stat & next_mask);

		// read data stand only in the cycle after the strobe
		next_rdata = 32'h00000000;
		if (I_RD) begin
			unique case (I_ADDR)
				NTU_REG_NOTCH:  next_rdata = {20'h00000, notch_set[10:7], 1'b0, notch_set[6:0]};
				NTU_REG_MODE:   next_rdata = {27'h0000000, f2_sel, tune, mode};
				NTU_REG_FILT1:  next_rdata = {16'h0000, filt1};
				NTU_REG_FILT2:  next_rdata = {16'h0000, filt2};
				NTU_REG_THRESH: next_rdata = {16'h0000, thresh};
				NTU_REG_FILT3:  next_rdata = {16'h0000, filt3};
				NTU_REG_FILT4:  next_rdata = {16'h0000, filt4};
				NTU_REG_FILT5:  next_rdata = {16'h0000, filt5};
				NTU_REG_STAT:   next_rdata = {29'h00000000, stat};
				NTU_REG_MASK:   next_rdata = {29'h00000000, mask};
				NTU_REG_COUNT:  next_rdata = {16'h0000, count};
				NTU_REG_LIVE:   next_rdata = {20'h00000, notch_live[10:7], 1'b0, notch_live[6:0]};
				default:        next_rdata = 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			notch_set    <= 11'h000;
			notch_live   <= 11'h000;
			mode         <= NTU_MODE_OFF;
			tune         <= NTU_TUNE_OFF;
			f2_sel       <= 1'b0;
			filt1        <= NTU_FILT_RST;
			filt2        <= NTU_FILT_RST;
			thresh       <= NTU_THRESH_RST;
			filt3        <= NTU_FILT_RST;
			filt4        <= NTU_FILT_RST;
			filt5        <= NTU_FILT_RST;
			stat         <= 3'h0;
			mask         <= 3'h0;
			count        <= 16'h0000;
			settle       <= 32'h00000000;
			warn_cnt     <= 32'h00000000;
			nvm_timer    <= 32'h00000000;
			nvm_dirty    <= 1'b0;
			O_RDATA      <= 32'h00000000;
			O_IRQ        <= 1'b0;
			O_NOTCH      <= '0;
			O_FILT_ONE   <= NTU_FILT_RST;
			O_FILT_TWO   <= NTU_FILT_RST;
			O_TOUGH_WARN <= 1'b0;
			O_NVM_SAVE   <= 1'b0;
		end else begin
			notch_set    <= next_notch_set;
			notch_live   <= next_notch_live;
			mode         <= next_mode;
			tune         <= next_tune;
			f2_sel       <= next_f2_sel;
			filt1        <= next_filt1;
			filt2        <= next_filt2;
			thresh       <= next_thresh;
			filt3        <= next_filt3;
			filt4        <= next_filt4;
			filt5        <= next_filt5;
			stat         <= next_stat;
			mask         <= next_mask;
			count        <= next_count;
			settle       <= next_settle;
			warn_cnt     <= next_warn_cnt;
			nvm_timer    <= next_nvm_timer;
			nvm_dirty    <= next_nvm_dirty;
			O_RDATA      <= next_rdata;
			O_IRQ        <= next_irq;
			O_NOTCH      <= live_dec;     // one cycle behind the live setting
			O_FILT_ONE   <= next_filt1;
			O_FILT_TWO   <= next_filt2;
			O_TOUGH_WARN <= next_warn;
			O_NVM_SAVE   <= save_now;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	low_freq_ignore_a: assert property (upd |-> I_DET.freq > NTU_MIN_DET_HZ)
		else $error("update issued for a component at or below 100 Hz");
	mode_off_idle_a: assert property (mode == NTU_MODE_OFF |-> !upd)
		else $error("update issued while supervisor is off");
	level_gate_a: assert property (upd |-> I_DET.level > thresh && I_DET.valid)
		else $error("update without level above threshold in a sample cycle");
	change_window_a: assert property (upd && mode == NTU_MODE_CHANGE |-> (win1 || win2))
		else $error("change mode update outside both bands");
	update_now_a: assert property (upd1 |=> filt1 == $past(I_DET.freq) ##1 O_FILT_ONE == filt1)
		else $error("filter one not rewritten at once");
	warn_count_a: assert property (upd |=> O_TOUGH_WARN && count == $past(count) + 16'h0001)
		else $error("warning or counter missing after update");
	tie_first_a: assert property (upd && f1_en && f2_en &&
		ntu_dist(I_DET.freq, filt1) == ntu_dist(I_DET.freq, filt2) |-> upd1 && !upd2)
		else $error("tie did not select filter one");
	far_filters_a: assert property (!(I_WR && I_ADDR == NTU_REG_FILT3) |=> $stable(filt3))
		else $error("filter three changed without a software write");
	nvm_spacing_a: assert property (save_now |=> !save_now ##0 nvm_timer == 32'h00000001)
		else $error("storage copy throttle not restarted");
	notch_lock_a: assert property (apply |-> I_SERVO_LOCK && $past(I_SERVO_LOCK)
		|| settle_need == 32'h00000001)
		else $error("notch setting applied without servo lock");

	upd_seen_c:   cover property (upd ##1 O_TOUGH_WARN);
	save_seen_c:  cover property (O_NVM_SAVE);
	apply_seen_c: cover property (apply ##2 O_NOTCH.enable);
	irq_seen_c:   cover property (O_IRQ ##[1:4] !O_IRQ);

endmodule // ntu_supervisor

`default_nettype wire

// ==== tb/ntu_servo_model.sv ====
// servo loop stand-in: resonance detector samples and servo lock status
`timescale 1ns/1ps
`default_nettype none

module ntu_servo_model
	import ntu_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_go,
	input  wire logic [15:0] i_level,
	input  wire logic [15:0] i_freq,
	input  wire logic        i_lock,
	output ntu_det_t         o_det,
	output logic             o_lock
);
	ntu_det_t next_det;

	// one sample per control cycle request; between samples the payload toggles
	// so a design that reads it without valid sees garbage, not a stale hit
	always_comb begin
		next_det = o_det;
		next_det.valid = i_go;
		if (i_go) begin
			next_det.level = i_level;
			next_det.freq = i_freq;
		end else begin
			next_det.level = ~o_det.level;
			next_det.freq = ~o_det.freq;
		end
	end

	// lock is registered like the detector, as it comes from the same loop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_det <= '0;
		end else begin
			o_det <= next_det;
		end
		o_lock <= i_lock;
	end
endmodule // ntu_servo_model

`default_nettype wire

// ==== tb/ntu_supervisor_tb.sv ====
// self-checking bench for the notch configuration and resonance supervisor
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin fails++; \
	$display("ERROR %s expected %h seen %h", n, e, v); end end

module ntu_supervisor_tb
	import ntu_pkg::*;
;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        go    = 1'b0;
	logic        lock  = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [15:0] lvl   = 16'h0;
	logic [15:0] frq   = 16'h0;
	logic [31:0] rdata, d;
	logic [15:0] o_f1, o_f2;
	logic        irq, warn, nvm, lock_s;
	ntu_det_t    det;
	ntu_notch_t  notch;
	int          fails = 0, total_checks = 0, cyc = 0, last_save = 2, saves = 0, n, cnt = 0;
	logic [7:0]  ra [9] = '{NTU_REG_FILT1, NTU_REG_FILT2, NTU_REG_FILT3, NTU_REG_FILT4, NTU_REG_FILT5,
		NTU_REG_THRESH, NTU_REG_MODE, NTU_REG_COUNT, 8'h30};
	logic [31:0] rv [9] = '{32'h1194, 32'h1194, 32'h1194, 32'h1194, 32'h1194, 32'h32, 32'h0, 32'h0, 32'h0};

	initial begin
		forever #50 clk = ~clk;
	end

	// short counts keep the run brief
	ntu_supervisor #(.P_SETTLE_FAST_CYC(5), .P_SETTLE_SLOW_CYC(12), .P_WARN_CYC(20), .P_NVM_CYC(50))
	ntu_supervisor_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.I_DET(det), .I_SERVO_LOCK(lock_s), .O_RDATA(rdata), .O_IRQ(irq), .O_NOTCH(notch),
		.O_FILT_ONE(o_f1), .O_FILT_TWO(o_f2), .O_TOUGH_WARN(warn), .O_NVM_SAVE(nvm));

	ntu_servo_model ntu_servo_model_inst (.i_clk(clk), .i_rst(rst), .i_go(go), .i_level(lvl), .i_freq(frq),
		.i_lock(lock), .o_det(det), .o_lock(lock_s));

	// ************************************************************
	// bus and detector tasks
	// ************************************************************
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// strobes are followed by an idle cycle so no signal is set twice at one edge
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
	endtask

	task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd_reg(a, d);
		`CHK(nm, e, d)
	endtask

	// one detector sample; filters are looked at just after the taking edge
	task automatic fire(input logic [15:0] l, input logic [15:0] f, input logic [15:0] e1,
		input logic [15:0] e2, input logic ew);
		lvl <= l;
		frq <= f;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("filter one", e1, o_f1)
		`CHK("filter two", e2, o_f2)
		if (ew) begin
			cnt++;
			`CHK("warning", 1'b1, warn)
		end
	endtask

	task automatic notch_chk(input logic [31:0] v, input logic [27:0] e);
		wr_reg(NTU_REG_NOTCH, v);
		repeat (8) @(posedge clk);
		chk_reg("live notch", NTU_REG_LIVE, v);
		`CHK("notch out", e, notch)
	endtask

	// storage pulse spacing and a hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (nvm === 1'b1) begin
			`CHK("save spacing", 1'b1, (cyc - last_save >= 50))
			last_save = cyc;
			saves++;
		end
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) chk_reg("reset value", ra[i], rv[i]);
		wr_reg(NTU_REG_MODE, 32'h3);
		chk_reg("mode", NTU_REG_MODE, 32'h0);
		fire(16'h0100, 16'h1388, 16'h1194, 16'h1194, 1'b0); // mode off
		wr_reg(NTU_REG_MASK, 32'h1);
		wr_reg(NTU_REG_MODE, 32'h9);
		fire(16'h0032, 16'h1388, 16'h1194, 16'h1194, 1'b0); // level equal to threshold
		fire(16'h0033, 16'h16DB, 16'h1194, 16'h1194, 1'b0); // 5851 Hz outside band
		fire(16'h0033, 16'h16DA, 16'h16DA, 16'h1194, 1'b1); // 5850 Hz band edge
		`CHK("irq raised", 1'b1, irq)
		n = 0;
		while (warn === 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
			#1;
		end
		`CHK("warning length", 20, n)
		rd_reg(NTU_REG_STAT, d);
		`CHK("status", 1'b1, d[0])
		`CHK("irq cleared", 1'b0, irq)
		rd_reg(NTU_REG_STAT, d);
		`CHK("status cleared", 1'b0, d[0])
		wr_reg(NTU_REG_MASK, 32'h0);
		wr_reg(NTU_REG_FILT1, 32'h64);
		fire(16'h0040, 16'h0064, 16'h0064, 16'h1194, 1'b0); // 100 Hz ignored
		fire(16'h0040, 16'h0065, 16'h0065, 16'h1194, 1'b1); // 101 Hz taken
		`CHK("irq masked", 1'b0, irq)
		wr_reg(NTU_REG_MODE, 32'h11);
		fire(16'h0040, 16'h0FA0, 16'h0065, 16'h0FA0, 1'b1);
		wr_reg(NTU_REG_MODE, 32'h19);
		wr_reg(NTU_REG_FILT1, 32'h3E8);
		wr_reg(NTU_REG_FILT2, 32'h7D0);
		fire(16'h0040, 16'h05DC, 16'h05DC, 16'h07D0, 1'b1); // midway goes to one
		fire(16'h0040, 16'h0708, 16'h05DC, 16'h0708, 1'b1); // nearer two
		wr_reg(NTU_REG_MODE, 32'h1);
		fire(16'h0040, 16'h0BB8, 16'h05DC, 16'h0708, 1'b0); // change mode, both off
		wr_reg(NTU_REG_MODE, 32'h2); // automatic mode preferred
		fire(16'h0040, 16'h0BB8, 16'h0BB8, 16'h0708, 1'b1);
		wr_reg(NTU_REG_MODE, 32'hA);
		fire(16'h0040, 16'h03E8, 16'h0BB8, 16'h03E8, 1'b1);
		wr_reg(NTU_REG_MODE, 32'h12);
		fire(16'h0040, 16'h1388, 16'h1388, 16'h03E8, 1'b1);
		chk_reg("update count", NTU_REG_COUNT, 32'(cnt));
		for (int i = 2; i < 5; i++) chk_reg("other filter", ra[i], 32'h1194);
		repeat (60) @(posedge clk);
		`CHK("saves seen", 1'b1, (saves > 0))
		wr_reg(NTU_REG_NOTCH, 32'hF01); // nearest code to 2000 Hz
		repeat (20) @(posedge clk);
		chk_reg("live while moving", NTU_REG_LIVE, 32'h0);
		lock <= 1'b1;
		chk_reg("live at lock", NTU_REG_LIVE, 32'h0);
		notch_chk(32'hF01, {1'b1, 18'h30D40, 9'h006});
		notch_chk(32'h816, {1'b1, 18'h02710, 9'h03C});
		notch_chk(32'h07F, {1'b1, 18'h00070, 9'h190});
		wr_reg(NTU_REG_NOTCH, 32'h0);
		repeat (8) @(posedge clk);
		chk_reg("slow wait", NTU_REG_LIVE, 32'h7F);
		repeat (8) @(posedge clk);
		chk_reg("notch off", NTU_REG_LIVE, 32'h0);
		`CHK("notch enable", 1'b0, notch.enable)
		chk_reg("status all", NTU_REG_STAT, 32'h7);
		results();
	end
endmodule // ntu_supervisor_tb

`default_nettype wire
